//--- verilog/octal_switch_spi_control.sv
// serial command and fault-report logic of an eight-channel load switch
`timescale 1ns/100ps

module octal_switch_spi_control
  import switch_ctl_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              serial_clock,
  input  wire logic              chip_select_n,
  input  wire logic              serial_command_in,
  output logic                   serial_status_out,
  output logic                   serial_status_oe,
  input  wire logic              enable_in,
  input  wire logic              logic_supply,
  input  wire logic              battery_supply,
  input  wire logic              direct_pwm_input_five,
  input  wire logic              direct_pwm_input_six,
  input  wire logic              overvoltage_flag,
  input  wire fault_flags_s      fault_flags,
  output driver_ctl_s            driver_ctl
);

  // three-stage synchronisers for the serial, pwm and power pins; overvoltage and fault flags are used unsynchronised
  localparam int unsigned SYNC_N = 7;
  logic [SYNC_N-1:0] pin_raw;
  logic [SYNC_N-1:0] s1_r, s2_r, s3_r;
  logic [SYNC_N-1:0] stable_r, stable_nxt;
  assign pin_raw = {battery_supply, logic_supply, enable_in, direct_pwm_input_six,
                    direct_pwm_input_five, serial_command_in, serial_clock};

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a level counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++) begin : g_filt
      always_comb begin
        stable_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : stable_r[gi];
      end
    end
  endgenerate

  // chip select idles high, so its chain presets to one
  logic cs1_r, cs2_r, cs3_r, cs_r, cs_nxt;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cs1_r    <= 1'b1;
      cs2_r    <= 1'b1;
      cs3_r    <= 1'b1;
      cs_r     <= 1'b1;
      stable_r <= '0;
    end else begin
      cs1_r    <= chip_select_n;
      cs2_r    <= cs1_r;
      cs3_r    <= cs2_r;
      cs_r     <= cs_nxt;
      stable_r <= stable_nxt;
    end
  end
  always_comb begin
    cs_nxt = (cs2_r == cs3_r) ? cs3_r : cs_r;
  end

  logic sclk_s, din_s, pwm5_s, pwm6_s, en_s, vdd_s, vpwr_s;
  assign {vpwr_s, vdd_s, en_s, pwm6_s, pwm5_s, din_s, sclk_s} = stable_r;

  // edge detection on the filtered levels
  logic sclk_d_r, cs_d_r, en_d_r, vdd_d_r, vpwr_d_r;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sclk_d_r <= 1'b0;
      cs_d_r   <= 1'b1;
      en_d_r   <= 1'b0;
      vdd_d_r  <= 1'b0;
      vpwr_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      cs_d_r   <= cs_r;
      en_d_r   <= en_s;
      vdd_d_r  <= vdd_s;
      vpwr_d_r <= vpwr_s;
    end
  end

  logic sclk_rise, sclk_fall, cs_fall, cs_rise, por_event, sleep;
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;
  assign cs_fall   = ~cs_r & cs_d_r;
  assign cs_rise   = cs_r & ~cs_d_r;
  // power-on reset on enable or supply rising; absent supply means sleep
  assign por_event = (en_s & ~en_d_r) | (vdd_s & ~vdd_d_r) | (vpwr_s & ~vpwr_d_r);
  assign sleep     = ~en_s | ~vdd_s | ~vpwr_s;

  // frame state, shift register, clock count, command register
  link_state_e       state_r, state_nxt;
  logic [WORD_W-1:0] shift_r, shift_nxt;
  logic [WORD_W-1:0] cmd_r, cmd_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic              dout_r, dout_nxt;
  logic [CHAN_N-1:0] status_now;
  logic              count_ok;

  // status capture: on-state open load hidden, off-state needs detect current
  always_comb begin
    status_now = fault_flags.short_fault | fault_flags.thermal_limit_flag
               | (fault_flags.open_load & ~cmd_r[ONOFF_LSB +: CHAN_N]
                  & cmd_r[DETECT_LSB +: CHAN_N]);
  end

  // 16 clocks, then any multiple of 8 more; count wraps at 256, so 256- and 264-clock frames are rejected
  assign count_ok = (cnt_r >= CNT_FIRST) && ((cnt_r[2:0] & STEP_MASK) == 3'h0);

  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    cmd_nxt   = cmd_r;
    cnt_nxt   = cnt_r;
    dout_nxt  = dout_r;
    unique case (state_r)
      LINK_IDLE: begin
        // clock and data ignored while deselected
        if (cs_fall) begin
          state_nxt = LINK_FRAME;
          // upper byte zero, fault flags of the previous state below
          shift_nxt = {{(WORD_W-CHAN_N){1'b0}}, status_now};
          cnt_nxt   = '0;
          dout_nxt  = 1'b0;
        end
      end
      LINK_FRAME: begin
        if (sclk_rise) begin
          dout_nxt = shift_r[WORD_W-1];
        end
        if (sclk_fall) begin
          shift_nxt = {shift_r[WORD_W-2:0], din_s};
          cnt_nxt   = cnt_r + 8'h01;
        end
        if (cs_rise) begin
          state_nxt = LINK_IDLE;
          if (count_ok) begin
            cmd_nxt = shift_r;
          end
        end
      end
    endcase
    if (sleep || por_event) begin
      state_nxt = LINK_IDLE;
      cmd_nxt   = CMD_RESET;
      cnt_nxt   = '0;
      dout_nxt  = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r <= LINK_IDLE;
      shift_r <= '0;
      cmd_r   <= CMD_RESET;
      cnt_r   <= '0;
      dout_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      cmd_r   <= cmd_nxt;
      cnt_r   <= cnt_nxt;
      dout_r  <= dout_nxt;
    end
  end

  // serial output drive; follows the filtered select, three to four cycles late
  assign serial_status_out = dout_r;
  assign serial_status_oe  = ~cs_r;

  // driver outputs registered; protection overrides without losing the command
  driver_ctl_s drv_r, drv_nxt;
  logic [CHAN_N-1:0] want_on;
  always_comb begin
    want_on = cmd_r[ONOFF_LSB +: CHAN_N];
    want_on[PWM_CH_A] = cmd_r[ONOFF_LSB + PWM_CH_A] | pwm5_s;
    want_on[PWM_CH_B] = cmd_r[ONOFF_LSB + PWM_CH_B] | pwm6_s;
    drv_nxt.drive = want_on & ~fault_flags.thermal_limit_flag
                  & {CHAN_N{~overvoltage_flag}};
    drv_nxt.detect_current = cmd_r[DETECT_LSB +: CHAN_N];
    if (sleep) begin
      drv_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      drv_r <= '0;
    end else begin
      drv_r <= drv_nxt;
    end
  end
  assign driver_ctl = drv_r;

  // checks
  property p_oe_follows_cs;
    @(posedge ref_clk) disable iff (reset)
      (cs2_r == cs3_r) |=> serial_status_oe == ~$past(cs3_r);
  endproperty
  a_oe_follows_cs: assert property (p_oe_follows_cs) else $error("oe not tied to select");

  property p_status_upper_zero;
    @(posedge ref_clk) disable iff (reset)
      (state_r == LINK_IDLE && cs_fall && !sleep && !por_event) |=>
        shift_r[WORD_W-1:CHAN_N] == '0 && shift_r[CHAN_N-1:0] == $past(status_now);
  endproperty
  a_status_upper_zero: assert property (p_status_upper_zero) else $error("bad status load");

  property p_hidden_open;
    @(posedge ref_clk) disable iff (reset)
      (!fault_flags.short_fault[0] && !fault_flags.thermal_limit_flag[0] &&
       !cmd_r[DETECT_LSB]) |-> !status_now[0];
  endproperty
  a_hidden_open: assert property (p_hidden_open) else $error("open load shown w/o current");

  property p_sleep_off;
    @(posedge ref_clk) disable iff (reset) sleep |=> driver_ctl == '0;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("outputs alive in sleep");

  property p_por_clears;
    @(posedge ref_clk) disable iff (reset) por_event |=> cmd_r == CMD_RESET;
  endproperty
  a_por_clears: assert property (p_por_clears) else $error("command kept over reset");

  property p_cmd_only_at_cs_rise;
    @(posedge ref_clk) disable iff (reset)
      (cmd_r != $past(cmd_r)) |-> $past(cs_rise) || $past(sleep) || $past(por_event);
  endproperty
  a_cmd_only_at_cs_rise: assert property (p_cmd_only_at_cs_rise) else $error("early update");

  property p_bad_count;
    @(posedge ref_clk) disable iff (reset)
      (state_r == LINK_FRAME && cs_rise && !count_ok && !sleep && !por_event) |=> $stable(cmd_r);
  endproperty
  a_bad_count: assert property (p_bad_count) else $error("bad count accepted");

  property p_overvolt;
    @(posedge ref_clk) disable iff (reset) overvoltage_flag |=> driver_ctl.drive == '0;
  endproperty
  a_overvolt: assert property (p_overvolt) else $error("output on in overvoltage");

  property p_pwm_or;
    @(posedge ref_clk) disable iff (reset)
      (pwm5_s && !sleep && !overvoltage_flag && !fault_flags.thermal_limit_flag[PWM_CH_A])
        |=> driver_ctl.drive[PWM_CH_A];
  endproperty
  a_pwm_or: assert property (p_pwm_or) else $error("pwm input ignored");

  c_good_frame: cover property (@(posedge ref_clk) disable iff (reset)
    state_r == LINK_FRAME && cs_rise && count_ok);
  c_chain_frame: cover property (@(posedge ref_clk) disable iff (reset)
    cs_rise && count_ok && cnt_r > CNT_FIRST);
  c_bad_frame: cover property (@(posedge ref_clk) disable iff (reset)
    state_r == LINK_FRAME && cs_rise && !count_ok);
  c_fault_seen: cover property (@(posedge ref_clk) disable iff (reset)
    cs_fall && status_now != '0);

endmodule : octal_switch_spi_control

//--- verilog/switch_ctl_pkg.sv
// shared constants and carrier types for the octal switch serial control
package switch_ctl_pkg;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned CHAN_N     = 8;
  localparam int unsigned CNT_W      = 8;
  localparam int unsigned FIRST_LEN  = 16;   // clocks for the first word
  localparam int unsigned STEP_LEN   = 8;    // clocks per further chunk
  localparam int unsigned ONOFF_LSB  = 0;    // on/off bits 7..0
  localparam int unsigned DETECT_LSB = 8;    // detect enable bits 15..8
  localparam int unsigned PWM_CH_A   = 4;    // output five
  localparam int unsigned PWM_CH_B   = 5;    // output six
  localparam logic [WORD_W-1:0] CMD_RESET = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_FIRST = 8'h10;
  localparam logic [2:0]        STEP_MASK = 3'h7;

  // per-output fault flags from the analog side, already filtered
  typedef struct packed {
    logic [CHAN_N-1:0] open_load;
    logic [CHAN_N-1:0] short_fault;
    logic [CHAN_N-1:0] thermal_limit_flag;
  } fault_flags_s;

  // per-output drive and detect current enables
  typedef struct packed {
    logic [CHAN_N-1:0] drive;
    logic [CHAN_N-1:0] detect_current;
  } driver_ctl_s;

  typedef enum logic [1:0] {
    LINK_IDLE  = 2'b01,
    LINK_FRAME = 2'b10
  } link_state_e;
endpackage : switch_ctl_pkg

//--- verification/spi_host_model.sv
// host-side serial master model that clocks frames into the switch
`timescale 1ns/100ps
module spi_host_model (
  input  wire logic        start,
  input  wire logic [5:0]  nbits,
  input  wire logic [31:0] tx,
  input  wire logic        miso,
  output logic             sclk,
  output logic             cs_n,
  output logic             mosi,
  output logic [31:0]      rx,
  output logic             done
);
  // idle: select high, clock standing low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    rx   = 32'h0;
    done = 1'b0;
  end

  // one frame per start; any count may be sent, legal ones are 16+8k
  always @(posedge start) begin
    rx = 32'h0;
    #213 cs_n = 1'b0;
    // lead time: clock stays low while the select edge passes the synchronisers
    #160;
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b1;
      #40 mosi = tx[nbits-1-i];  // msb first, stable across the fall
      #40 sclk = 1'b0;
      // capture late in the low phase: the synchronised answer lags the rise
      #80 rx = {rx[30:0], miso};  // status flows back each clock
    end
    cs_n = 1'b1;
    mosi = ~mosi;  // released line shows no stale value
    #300 done = 1'b1;
    #20 done = 1'b0;
  end
endmodule : spi_host_model

//--- verification/octal_switch_spi_control_test.sv
// self-checking bench for the octal switch serial control
`timescale 1ns/100ps
module octal_switch_spi_control_test;
  import switch_ctl_pkg::*;
  logic         ref_clk = 1'b0;
  logic         reset   = 1'b1;
  logic [2:0]   pwr     = 3'h7;  // enable, logic supply, battery supply
  logic         pwm5    = 1'b0;
  logic         pwm6    = 1'b0;
  logic         ov      = 1'b0;
  fault_flags_s flt     = '0;
  driver_ctl_s  drv;
  logic         sclk, cs_n, mosi, miso, oe, done, dout;
  logic         start   = 1'b0;
  logic [5:0]   nbits   = 6'h10;
  logic [5:0]   lens[6] = '{6'h08, 6'h0c, 6'h10, 6'h11, 6'h18, 6'h20};
  logic [31:0]  tx      = 32'h0;
  logic [31:0]  rx, r;
  logic [31:0]  rnd     = 32'h7b86;
  logic [15:0]  cmd     = 16'h0;
  logic [47:0]  notes[$];
  int           miscompares = 0;
  int           cmp_count   = 0;
  int           cycles      = 0;

  always #10 ref_clk = ~ref_clk;

  octal_switch_spi_control i_octal_switch_spi_control (
    .ref_clk(ref_clk), .reset(reset), .serial_clock(sclk), .chip_select_n(cs_n),
    .serial_command_in(mosi), .serial_status_out(dout), .serial_status_oe(oe),
    .enable_in(pwr[0]), .logic_supply(pwr[1]), .battery_supply(pwr[2]),
    .direct_pwm_input_five(pwm5), .direct_pwm_input_six(pwm6),
    .overvoltage_flag(ov), .fault_flags(flt), .driver_ctl(drv));

  // released line shows the inverse of the last bit, so a late enable is caught
  assign miso = oe ? dout : ~dout;

  spi_host_model i_spi_host_model (
    .start(start), .nbits(nbits), .tx(tx), .miso(miso), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .rx(rx), .done(done));

  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction : xs

  // pwm inputs ORed in before the protection masks
  function automatic driver_ctl_s exp_drv();
    logic [7:0] on;
    on = (cmd[7:0] | {2'h0, pwm6, pwm5, 4'h0}) & ~flt.thermal_limit_flag & {8{~ov}};
    return {on, cmd[15:8]};
  endfunction : exp_drv

  // outgoing stream: zero byte, status byte, then earlier-shifted bits
  // s is the full 16-bit status word, upper byte zero
  function automatic logic [31:0] exp_rx(logic [15:0] s);
    logic [31:0] q;
    q = 32'h0;
    for (int k = 0; k < nbits; k++)
      q = {q[30:0], (k < 16) ? s[15-k] : tx[nbits+15-k]};
    return q;
  endfunction : exp_rx

  task automatic check(logic [47:0] seen, logic [47:0] want, string what);
    cmp_count++;
    if (seen !== want) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, seen, want);
    end
  endtask : check

  task automatic frame(logic [5:0] n, logic [31:0] t);
    logic [7:0] s;
    @(negedge ref_clk);
    nbits = n;
    tx = t;
    s = flt.short_fault | flt.thermal_limit_flag | (flt.open_load & ~cmd[7:0] & cmd[15:8]);
    if (n >= 6'h10 && n[2:0] == 3'h0) cmd = t[15:0];  // last 16 bits
    notes.push_back({exp_rx({8'h00, s}), exp_drv()});
    start = 1'b1;
    @(negedge ref_clk) start = 1'b0;
    @(posedge done);
    @(negedge ref_clk);
  endtask : frame

  task automatic settle_check();
    repeat (10) @(negedge ref_clk);
    check(48'(drv), 48'(exp_drv()), "drive");
  endtask : settle_check

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // result watcher: oldest note against what the frame returned
  always @(posedge done) begin
    check({rx, 16'(drv)}, notes.pop_front(), "frame");
    check(48'(oe), 48'h0, "oe idle");
  end

  // output driven at every clock fall of the selected frame
  always @(negedge sclk) if (!cs_n) check(48'(oe), 48'h1, "oe frame");

  // hang guard, far above the expected few thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk) reset = 1'b0;
    repeat (12) @(negedge ref_clk);
    // random faults, words and counts; pwm held low for serial control
    for (int i = 0; i < 18; i++) begin
      r = xs();
      flt.open_load = r[7:0];
      flt.short_fault = r[15:8] & r[23:16] & r[31:24];
      r = xs();
      flt.thermal_limit_flag = r[7:0] & r[15:8] & r[23:16];
      frame(lens[r[31:24] % 6], xs());
    end
    flt = '0;
    $display("test random frames done");
    // each power pin: sleep clears drive, rise clears command
    for (int i = 0; i < 3; i++) begin
      frame(6'h10, 32'h0000ffff);
      pwr[i] = 1'b0;
      cmd = 16'h0;
      settle_check();
      pwr[i] = 1'b1;
      settle_check();
    end
    $display("test power reset done");
    // pwm pins with their command bits kept zero
    frame(6'h10, 32'h0000ffcf);
    for (int v = 1; v < 5; v++) begin
      {pwm6, pwm5} = 2'(v);
      settle_check();
    end
    $display("test pwm done");
    ov = 1'b1;
    settle_check();
    ov = 1'b0;
    settle_check();
    flt.thermal_limit_flag = 8'h81;
    settle_check();
    flt.thermal_limit_flag = 8'h00;
    settle_check();
    $display("test shutdown done");
    wrap_up();
  end
endmodule : octal_switch_spi_control_test
